// File: hw/caption_host_ctrl.sv
/*
 * Caption field enables, caption byte pairs with write status, software reset,
 * power down and analog output disables, reached over AHB-Lite.
 * Assumes video timing logic on hclk gives a line start pulse, line number,
 * field parity and line standard.
 */
// Operation
// - enable field bits 7-6; 00 inserts no captions at all
// - 01 inserts odd-field captions on line 21, 18 or 22
// - 10 inserts even-field captions on line 284, 281 or 335
// - 11 inserts captions in both odd and even fields
// - host control bit 7 starts soft reset, clears itself when done
// - host control bit 6 set selects power down
// - bits 5,2,1,0 disable composite 2, composite 1, luma, chroma outputs
// - bit 4 reads zero while odd pair is unsent, one after output
// - bit 3 reads zero while even pair is unsent, one after output
// - odd pair forms 16-bit word, sent from bit 0 of first byte
// - even pair forms 16-bit word, sent from bit 0 of first byte
// - second even byte is 8 bits, resets to 80, upper half
`timescale 1ns/1ps
`include "caption_consts.svh"

module caption_host_ctrl #(
    parameter int SRST_CYCLES = `SRST_CYCLES,
    parameter int BIT_CYCLES = `CAPTION_BIT_CYCLES
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic line_start,
    input wire logic [9:0] line_number,
    input wire logic odd_field,
    input wire logic [1:0] video_std,
    output logic caption_data,
    output logic caption_active,
    output logic soft_reset_active,
    output logic power_down,
    output logic [3:0] dac_disable,
    output logic irq
);
    caption_if odd_cap ();
    caption_if even_cap ();

    logic [7:0] aux_r;
    logic [7:0] host_r;
    logic odd_status_r;
    logic even_status_r;
    logic [7:0] odd_low_r;
    logic [7:0] odd_high_r;
    logic [7:0] even_low_r;
    logic [7:0] even_high_r;
    logic [`IRQ_BITS-1:0] irq_status_r;
    logic [`IRQ_BITS-1:0] irq_mask_r;
    logic wr_pend_r;
    logic rd_wait_r;
    logic [7:0] idx_r;
    logic [7:0] srst_cnt_r;
    logic srst_end_r;
    logic [31:0] hrdata_r;
    logic caption_data_r;
    logic caption_active_r;
    logic power_down_r;
    logic [3:0] dac_disable_r;
    logic addr_phase;
    logic wr_en;
    logic [7:0] wdata;
    logic odd_line;
    logic even_line;

    initial begin
        if (SRST_CYCLES < 1 || SRST_CYCLES > 255) begin
            $error("SRST_CYCLES must lie in 1..255");
        end
    end

    // designated caption line for the field and line standard
    function automatic logic [9:0] caption_line(input logic [1:0] vstd, input logic even);
        logic [9:0] line;
        line = even ? `LINE_EVEN_PAL : `LINE_ODD_PAL;
        if (vstd == caption_pkg::STD_525) begin
            line = even ? `LINE_EVEN_525 : `LINE_ODD_525;
        end else if (vstd == caption_pkg::STD_PAL_M) begin
            line = even ? `LINE_EVEN_PAL_M : `LINE_ODD_PAL_M;
        end
        return line;
    endfunction

    // true when a write of the current data phase hits this index
    function automatic logic hit(input logic en, input logic [7:0] idx, input logic [7:0] want);
        return en && idx == want;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // bus slave: writes take no wait, reads one wait so a read right after a
    // write sees the new value; every transfer is answered OKAY
    assign addr_phase = hsel && htrans[1] && hready;
    assign wr_en = wr_pend_r;
    assign wdata = hwdata[7:0];
    assign hreadyout = !rd_wait_r;
    assign hresp = 1'b0;
    assign hrdata = hrdata_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            rd_wait_r <= 1'b0;
            idx_r <= 8'h00;
        end else begin
            wr_pend_r <= addr_phase && hwrite;
            rd_wait_r <= addr_phase && !hwrite;
            if (addr_phase) begin
                idx_r <= haddr[`IDX_MSB:`IDX_LSB];
            end
        end
    end

    // read mux, loaded during the wait cycle; unmapped reads give zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_r <= 32'h0000_0000;
        end else if (rd_wait_r) begin
            case (idx_r)
                `IDX_AUX_ENABLE: hrdata_r <= {24'h000000, aux_r};
                `IDX_HOST_CTRL: hrdata_r <= {24'h000000, host_r[7:5], odd_status_r,
                    even_status_r, host_r[2:0]};
                `IDX_ODD_LOW: hrdata_r <= {24'h000000, odd_low_r};
                `IDX_ODD_HIGH: hrdata_r <= {24'h000000, odd_high_r};
                `IDX_EVEN_LOW: hrdata_r <= {24'h000000, even_low_r};
                `IDX_EVEN_HIGH: hrdata_r <= {24'h000000, even_high_r};
                `IDX_IRQ_STATUS: hrdata_r <= {29'h0, irq_status_r};
                `IDX_IRQ_MASK: hrdata_r <= {29'h0, irq_mask_r};
                default: hrdata_r <= 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // control registers; status bits 4 and 3 are not stored here
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            aux_r <= `AUX_RESET;
            host_r <= `HOST_CTRL_RESET;
            irq_mask_r <= '0;
        end else begin
            if (hit(wr_en, idx_r, `IDX_AUX_ENABLE)) begin
                aux_r <= {wdata[`CAP_EN_MSB:`CAP_EN_LSB], 6'h00};
            end
            if (hit(wr_en, idx_r, `IDX_IRQ_MASK)) begin
                irq_mask_r <= wdata[`IRQ_BITS-1:0];
            end
            if (hit(wr_en, idx_r, `IDX_HOST_CTRL)) begin
                host_r <= {wdata[7:5] | {host_r[`HC_SOFT_RESET], 2'b00}, 2'b00, wdata[2:0]};
            end else if (srst_end_r) begin
                host_r[`HC_SOFT_RESET] <= 1'b0;
            end
        end
    end

    // soft reset sequence: a fixed count while bit 7 stands, then it clears
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            srst_cnt_r <= 8'h00;
            srst_end_r <= 1'b0;
        end else begin
            srst_end_r <= 1'b0;
            if (host_r[`HC_SOFT_RESET] && !srst_end_r) begin
                if (srst_cnt_r == 8'(SRST_CYCLES - 1)) begin
                    srst_cnt_r <= 8'h00;
                    srst_end_r <= 1'b1;
                end else begin
                    srst_cnt_r <= srst_cnt_r + 8'h01;
                end
            end
        end
    end
    assign soft_reset_active = host_r[`HC_SOFT_RESET];

    ////////////////////////////////////////////////////////////////////////////////
    // caption bytes; soft reset restores them to their reset value
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            odd_low_r <= `CAPTION_RESET;
            odd_high_r <= `CAPTION_RESET;
            even_low_r <= `CAPTION_RESET;
            even_high_r <= `CAPTION_RESET;
        end else if (soft_reset_active) begin
            odd_low_r <= `CAPTION_RESET;
            odd_high_r <= `CAPTION_RESET;
            even_low_r <= `CAPTION_RESET;
            even_high_r <= `CAPTION_RESET;
        end else begin
            if (hit(wr_en, idx_r, `IDX_ODD_LOW)) odd_low_r <= wdata;
            if (hit(wr_en, idx_r, `IDX_ODD_HIGH)) odd_high_r <= wdata;
            if (hit(wr_en, idx_r, `IDX_EVEN_LOW)) even_low_r <= wdata;
            if (hit(wr_en, idx_r, `IDX_EVEN_HIGH)) even_high_r <= wdata;
        end
    end

    // write status: finishing a pair sets, a byte write clears; set wins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            odd_status_r <= 1'b1;
            even_status_r <= 1'b1;
        end else if (soft_reset_active) begin
            odd_status_r <= 1'b1;
            even_status_r <= 1'b1;
        end else begin
            if (odd_cap.done) begin
                odd_status_r <= 1'b1;
            end else if (hit(wr_en, idx_r, `IDX_ODD_LOW) || hit(wr_en, idx_r, `IDX_ODD_HIGH)) begin
                odd_status_r <= 1'b0;
            end
            if (even_cap.done) begin
                even_status_r <= 1'b1;
            end else if (hit(wr_en, idx_r, `IDX_EVEN_LOW) ||
                hit(wr_en, idx_r, `IDX_EVEN_HIGH)) begin
                even_status_r <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // launch a pair at the start of its caption line when its field is enabled
    assign odd_line = line_start && odd_field &&
        line_number == caption_line(video_std, 1'b0);
    assign even_line = line_start && !odd_field &&
        line_number == caption_line(video_std, 1'b1);
    assign odd_cap.start = odd_line && aux_r[`CAP_EN_LSB + `CAP_EN_ODD] &&
        !odd_cap.busy && !soft_reset_active;
    assign even_cap.start = even_line && aux_r[`CAP_EN_LSB + `CAP_EN_EVEN] &&
        !even_cap.busy && !soft_reset_active;
    assign odd_cap.word = {odd_high_r, odd_low_r};
    assign even_cap.word = {even_high_r, even_low_r};
    assign odd_cap.abort = soft_reset_active;
    assign even_cap.abort = soft_reset_active;

    caption_serializer #(.BIT_CYCLES(BIT_CYCLES)) odd_ser (
        .hclk(hclk),
        .hresetn(hresetn),
        .cap(odd_cap)
    );

    caption_serializer #(.BIT_CYCLES(BIT_CYCLES)) even_ser (
        .hclk(hclk),
        .hresetn(hresetn),
        .cap(even_cap)
    );

    // output stage; the two fields never shift at once, so an or merges them
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            caption_data_r <= 1'b0;
            caption_active_r <= 1'b0;
            power_down_r <= 1'b0;
            dac_disable_r <= 4'h0;
        end else begin
            caption_data_r <= (odd_cap.bit_valid & odd_cap.bit_out) |
                (even_cap.bit_valid & even_cap.bit_out);
            caption_active_r <= odd_cap.bit_valid | even_cap.bit_valid;
            power_down_r <= host_r[`HC_POWER_DOWN];
            dac_disable_r <= {host_r[`HC_OUT2_OFF], host_r[`HC_OUT1_OFF],
                host_r[`HC_LUMA_OFF], host_r[`HC_CHROMA_OFF]};
        end
    end
    assign caption_data = caption_data_r;
    assign caption_active = caption_active_r;
    assign power_down = power_down_r;
    assign dac_disable = dac_disable_r;

    ////////////////////////////////////////////////////////////////////////////////
    // interrupts: sticky events, write one to clear, set wins over clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_status_r <= '0;
        end else begin
            for (int i = 0; i < `IRQ_BITS; i++) begin
                if ((i == `IRQ_ODD_SENT && odd_cap.done) ||
                    (i == `IRQ_EVEN_SENT && even_cap.done) ||
                    (i == `IRQ_SRST_DONE && srst_end_r)) begin
                    irq_status_r[i] <= 1'b1;
                end else if (hit(wr_en, idx_r, `IDX_IRQ_STATUS) && wdata[i]) begin
                    irq_status_r[i] <= 1'b0;
                end
            end
        end
    end
    assign irq = |(irq_status_r & irq_mask_r);

    ////////////////////////////////////////////////////////////////////////////////
    a_off_no_start: assert property (@(posedge hclk) disable iff (!hresetn)
        aux_r[`CAP_EN_MSB:`CAP_EN_LSB] == 2'b00 |-> !odd_cap.start && !even_cap.start)
        else $error("caption launched while disabled");
    a_odd_line: assert property (@(posedge hclk) disable iff (!hresetn)
        odd_cap.start |-> odd_field && line_number == caption_line(video_std, 1'b0))
        else $error("odd caption on wrong line");
    a_even_line: assert property (@(posedge hclk) disable iff (!hresetn)
        even_cap.start |-> !odd_field && line_number == caption_line(video_std, 1'b1))
        else $error("even caption on wrong line");
    a_both_fields: assert property (@(posedge hclk) disable iff (!hresetn)
        aux_r[`CAP_EN_MSB:`CAP_EN_LSB] == 2'b11 && odd_line && !odd_cap.busy &&
        !soft_reset_active |-> odd_cap.start)
        else $error("odd caption missed with both fields on");
    a_srst_clears: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(host_r[`HC_SOFT_RESET]) |-> ##[1:260] !host_r[`HC_SOFT_RESET])
        else $error("soft reset bit did not clear");
    a_power_down: assert property (@(posedge hclk) disable iff (!hresetn)
        hit(wr_en, idx_r, `IDX_HOST_CTRL) |-> ##2 power_down == $past(wdata[`HC_POWER_DOWN], 2))
        else $error("power down does not follow bit 6");
    a_dac_disable: assert property (@(posedge hclk) disable iff (!hresetn)
        hit(wr_en, idx_r, `IDX_HOST_CTRL) |-> ##2 dac_disable ==
        {$past(wdata[5], 2), $past(wdata[2], 2), $past(wdata[1], 2), $past(wdata[0], 2)})
        else $error("output disables do not follow host control");
    a_odd_sent: assert property (@(posedge hclk) disable iff (!hresetn)
        odd_cap.done && !soft_reset_active |=> odd_status_r)
        else $error("odd status not set after output");
    a_even_sent: assert property (@(posedge hclk) disable iff (!hresetn)
        even_cap.done && !soft_reset_active |=> even_status_r)
        else $error("even status not set after output");
    a_write_clears: assert property (@(posedge hclk) disable iff (!hresetn)
        hit(wr_en, idx_r, `IDX_EVEN_HIGH) && !even_cap.done && !soft_reset_active
        |=> !even_status_r)
        else $error("even status not cleared by a byte write");
    a_high_reset: assert property (@(posedge hclk) disable iff (!hresetn)
        srst_end_r |=> even_high_r == `CAPTION_RESET)
        else $error("second even byte not restored");
endmodule

// File: hw/caption_consts.svh
/*
 * Register indices, field positions, reset values and counts of the caption and host
 * control block. Assumes a byte address of four times the index on a 32-bit bus.
 */
`ifndef CAPTION_CONSTS_SVH
`define CAPTION_CONSTS_SVH

// register indices; byte address is index times four
`define IDX_AUX_ENABLE 8'h06
`define IDX_HOST_CTRL 8'h0f
`define IDX_ODD_LOW 8'h10
`define IDX_ODD_HIGH 8'h11
`define IDX_EVEN_LOW 8'h12
`define IDX_EVEN_HIGH 8'h13
`define IDX_IRQ_STATUS 8'h30
`define IDX_IRQ_MASK 8'h31
`define IDX_MSB 9
`define IDX_LSB 2

// auxiliary data enable field; low bit of the field odd fields, high bit even fields
`define CAP_EN_MSB 7
`define CAP_EN_LSB 6
`define CAP_EN_ODD 0
`define CAP_EN_EVEN 1

// host control fields
`define HC_SOFT_RESET 7
`define HC_POWER_DOWN 6
`define HC_OUT2_OFF 5
`define HC_ODD_STATUS 4
`define HC_EVEN_STATUS 3
`define HC_OUT1_OFF 2
`define HC_LUMA_OFF 1
`define HC_CHROMA_OFF 0

// interrupt status bits
`define IRQ_ODD_SENT 0
`define IRQ_EVEN_SENT 1
`define IRQ_SRST_DONE 2
`define IRQ_BITS 3

// reset values
`define CAPTION_RESET 8'h80
`define AUX_RESET 8'h00
`define HOST_CTRL_RESET 8'h00

// caption line numbers per standard
`define LINE_ODD_525 10'd21
`define LINE_ODD_PAL_M 10'd18
`define LINE_ODD_PAL 10'd22
`define LINE_EVEN_525 10'd284
`define LINE_EVEN_PAL_M 10'd281
`define LINE_EVEN_PAL 10'd335

// timing counts in hclk cycles
`define SRST_CYCLES 16
`define CAPTION_BIT_CYCLES 8

`endif

// File: hw/caption_pkg.sv
/*
 * Types shared by the caption control block and its serialiser.
 * Assumes nothing of its surroundings.
 */
package caption_pkg;
    // line standard reported by the video timing logic
    typedef enum logic [1:0] {
        STD_525 = 2'b00,
        STD_PAL_M = 2'b01,
        STD_PAL = 2'b11
    } video_std_type;

    // serialiser states
    typedef enum logic [1:0] {
        SER_IDLE = 2'b00,
        SER_SHIFT = 2'b01
    } ser_state_type;
endpackage

// File: hw/caption_if.sv
/*
 * Link between the register side and one caption serialiser.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps

interface caption_if;
    logic start;
    logic [15:0] word;
    logic abort;
    logic bit_out;
    logic bit_valid;
    logic done;
    logic busy;
    modport ctrl (output start, output word, output abort,
        input bit_out, input bit_valid, input done, input busy);
    modport ser (input start, input word, input abort,
        output bit_out, output bit_valid, output done, output busy);
endinterface

// File: hw/caption_serializer.sv
/*
 * Shifts one 16-bit caption word out, least significant bit first, holding each bit
 * for BIT_CYCLES clocks. Assumes start is only raised while busy is low.
 */
`timescale 1ns/1ps
`include "caption_consts.svh"

module caption_serializer #(
    parameter int BIT_CYCLES = `CAPTION_BIT_CYCLES
) (
    input wire logic hclk,
    input wire logic hresetn,
    caption_if.ser cap
);
    caption_pkg::ser_state_type state_r;
    logic [15:0] shift_r;
    logic [3:0] bit_idx_r;
    logic [7:0] phase_r;
    logic done_r;
    logic [11:0] run_len_r;

    initial begin
        if (BIT_CYCLES < 1 || BIT_CYCLES > 255) begin
            $error("BIT_CYCLES must lie in 1..255");
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // shifter: word loaded at start, bit 0 of the first byte goes out first
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r <= caption_pkg::SER_IDLE;
            shift_r <= 16'h0000;
            bit_idx_r <= 4'h0;
            phase_r <= 8'h00;
        end else if (cap.abort) begin
            state_r <= caption_pkg::SER_IDLE;
        end else begin
            case (state_r)
                caption_pkg::SER_IDLE: begin
                    if (cap.start) begin
                        state_r <= caption_pkg::SER_SHIFT;
                        shift_r <= cap.word;
                        bit_idx_r <= 4'h0;
                        phase_r <= 8'h00;
                    end
                end
                caption_pkg::SER_SHIFT: begin
                    if (phase_r == 8'(BIT_CYCLES - 1)) begin
                        phase_r <= 8'h00;
                        shift_r <= {1'b0, shift_r[15:1]};
                        bit_idx_r <= bit_idx_r + 4'h1;
                        if (bit_idx_r == 4'hf) begin
                            state_r <= caption_pkg::SER_IDLE;
                        end
                    end else begin
                        phase_r <= phase_r + 8'h01;
                    end
                end
                default: state_r <= caption_pkg::SER_IDLE;
            endcase
        end
    end

    // done pulses once, on the edge the last bit ends; an abort gives no done
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            done_r <= 1'b0;
        end else begin
            done_r <= !cap.abort && state_r == caption_pkg::SER_SHIFT &&
                bit_idx_r == 4'hf && phase_r == 8'(BIT_CYCLES - 1);
        end
    end

    assign cap.bit_out = shift_r[0];
    assign cap.bit_valid = (state_r == caption_pkg::SER_SHIFT);
    assign cap.busy = (state_r == caption_pkg::SER_SHIFT);
    assign cap.done = done_r;

    ////////////////////////////////////////////////////////////////////////////////
    a_lsb_first: assert property (@(posedge hclk) disable iff (!hresetn)
        cap.start && !cap.busy && !cap.abort |=> cap.bit_valid && cap.bit_out == $past(cap.word[0]))
        else $error("first caption bit is not bit 0 of the first byte");
    // checker helper: cycles spent shifting since the last accepted start
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            run_len_r <= 12'h000;
        end else if (cap.start && !cap.busy && !cap.abort) begin
            run_len_r <= 12'h000;
        end else if (cap.busy) begin
            run_len_r <= run_len_r + 12'h001;
        end
    end

    a_word_length: assert property (@(posedge hclk) disable iff (!hresetn)
        cap.done |-> run_len_r == 12'(16 * BIT_CYCLES))
        else $error("caption word length is not sixteen bits");
    a_word_done: assert property (@(posedge hclk) disable iff (!hresetn)
        cap.busy && !cap.abort && run_len_r == 12'(16 * BIT_CYCLES - 1) |=> cap.done)
        else $error("caption word did not finish");
endmodule

// File: sim/tb.sv
/*
 * Self-checking bench for caption_host_ctrl: register resets, caption sends per
 * standard and field, write status, irq, host control bits and soft reset.
 * Assumes the bench is the only AHB-Lite master and the only timing source.
 */
`timescale 1ns/1ps
`include "caption_consts.svh"

module tb;
logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, line_start = 0, odd_field = 0;
logic hreadyout, hresp, caption_data, caption_active, soft_reset_active, power_down, irq;
logic [31:0] haddr = 0, hwdata = 0, hrdata, q;
logic [31:0] seed = 32'h89fb;
logic [1:0] htrans = 0, video_std = 0;
logic [9:0] line_number = 0;
logic [3:0] dac_disable;
logic [15:0] w;
logic [7:0] lo, hi, d;
int n_errors = 0, num_checks = 0, cyc = 0, i, k, f;
int lines[6] = '{21, 18, 22, 284, 281, 335};
logic [1:0] stds[3] = '{2'h0, 2'h1, 2'h3};

////////////////////////////////////////////////////////////////////////////////
// short counts keep each caption word at 16 cycles
always #4 hclk = ~hclk;
caption_host_ctrl #(.SRST_CYCLES(2), .BIT_CYCLES(1)) u_dut (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .line_start(line_start), .line_number(line_number),
    .odd_field(odd_field), .video_std(video_std), .caption_data(caption_data),
    .caption_active(caption_active), .soft_reset_active(soft_reset_active),
    .power_down(power_down), .dac_disable(dac_disable), .irq(irq));

// hang guard, far above the few hundred cycles the run needs
always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
        n_errors++;
        close_out();
    end
end

////////////////////////////////////////////////////////////////////////////////
function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
endfunction

task automatic close_out();
    if (n_errors == 0 && num_checks > 0) begin
        $display("TEST PASSED");
    end else begin
        $display("TEST FAILED");
    end
    $finish;
endtask

task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
        n_errors++;
        $display("BAD %0t got %h want %h", $time, got, exp);
    end
endtask

// hready looked at just before the edge, so no race with the slave's update
task automatic waitrdy();
    @(negedge hclk);
    while (hreadyout !== 1'b1) @(negedge hclk);
    q = hrdata;
    @(posedge hclk);
endtask

task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] dat);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {22'h0, idx, 2'h0};
    waitrdy();
    htrans <= 2'h0;
    hwdata <= {24'h0, dat};
    waitrdy();
endtask

task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
    xfer(1'b0, idx, 8'h00);
    chk(q, exp);
    chk({31'h0, hresp}, 32'h0);
endtask

task automatic line(input logic [9:0] n, input logic odd);
    line_start <= 1'b1;
    line_number <= n;
    odd_field <= odd;
    @(posedge hclk);
    line_start <= 1'b0;
endtask

// a refused line must leave the serial output idle
task automatic quiet(input logic [9:0] n, input logic odd);
    line(n, odd);
    repeat (4) @(posedge hclk);
    chk({31'h0, caption_active}, 32'h0);
endtask

// one bit per cycle while active; active must drop right after bit 15
task automatic cap(output logic [15:0] wv);
    int j;
    wv = '0;
    for (j = 0; j < 20 && caption_active !== 1'b1; j++) @(negedge hclk);
    for (j = 0; j < 16; j++) begin
        wv[j] = caption_data;
        @(negedge hclk);
    end
    chk({31'h0, caption_active}, 32'h0);
    @(posedge hclk);
endtask

////////////////////////////////////////////////////////////////////////////////
initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(`IDX_AUX_ENABLE, 32'h0);
    rd(`IDX_HOST_CTRL, 32'h18);
    for (i = 0; i < 4; i++) rd(8'(8'h10 + i), 32'h80);
    rd(8'h20, 32'h0);
    // every standard, each field; the last standard uses the both-fields code
    for (k = 0; k < 3; k++) begin
        for (f = 0; f < 2; f++) begin
            video_std <= stds[k];
            lo = 8'(rnd());
            hi = 8'(rnd());
            xfer(1'b1, 8'(8'h10 + 2 * f), lo);
            xfer(1'b1, 8'(8'h11 + 2 * f), hi);
            rd(`IDX_HOST_CTRL, f ? 32'h10 : 32'h08);
            xfer(1'b1, `IDX_AUX_ENABLE, 8'h00);
            quiet(10'(lines[3 * f + k]), f == 0);
            rd(`IDX_HOST_CTRL, f ? 32'h10 : 32'h08);
            xfer(1'b1, `IDX_AUX_ENABLE, k == 2 ? 8'hc0 : (f ? 8'h80 : 8'h40));
            quiet(10'(lines[3 * f + k] + 1), f == 0);
            quiet(10'(lines[3 * f + k]), f != 0);
            line(10'(lines[3 * f + k]), f == 0);
            cap(w);
            chk({16'h0, w}, {16'h0, hi, lo});
            rd(`IDX_HOST_CTRL, 32'h18);
        end
    end
    // sticky status, mask, write-one-to-clear
    rd(`IDX_IRQ_STATUS, 32'h3);
    chk({31'h0, irq}, 32'h0);
    xfer(1'b1, `IDX_IRQ_MASK, 8'h07);
    @(negedge hclk);
    chk({31'h0, irq}, 32'h1);
    @(posedge hclk);
    xfer(1'b1, `IDX_IRQ_STATUS, 8'h01);
    rd(`IDX_IRQ_STATUS, 32'h2);
    xfer(1'b1, `IDX_IRQ_STATUS, 8'h02);
    @(negedge hclk);
    chk({31'h0, irq}, 32'h0);
    @(posedge hclk);
    // status bits are read-only, bits 6, 5 and 2-0 follow the write
    for (i = 0; i < 4; i++) begin
        d = 8'(rnd()) & 8'h67;
        xfer(1'b1, `IDX_HOST_CTRL, d);
        rd(`IDX_HOST_CTRL, {24'h0, d | 8'h18});
        @(negedge hclk);
        chk({27'h0, power_down, dac_disable}, {27'h0, d[6], d[5], d[2:0]});
        @(posedge hclk);
    end
    // soft reset with an unsent odd pair pending
    xfer(1'b1, `IDX_ODD_LOW, 8'(rnd()));
    xfer(1'b1, `IDX_HOST_CTRL, 8'h80);
    @(negedge hclk);
    chk({31'h0, soft_reset_active}, 32'h1);
    repeat (8) @(posedge hclk);
    rd(`IDX_HOST_CTRL, 32'h18);
    rd(`IDX_ODD_LOW, 32'h80);
    rd(`IDX_IRQ_STATUS, 32'h4);
    chk({31'h0, irq}, 32'h1);
    close_out();
end
endmodule
